// [lcdsd_pkg.sv]
// Overview of operation
// (R1) Thirty-two segment outputs and four common outputs drive up to 32 by 4 dots.
// (R2) Drive mode is a build-time choice among five bias and duty combinations.
// (R3) Alternating frequency is the source clock divided by 64, 128, 256 or 512.
// (R4) Frame rate is alternating frequency over number of commons in use.
// (R5) Thirty-two display RAM entries of four bits; entry n controls segment n.
// (R6) Hardware refreshes segment outputs from display RAM with no processor action.
// (R7) RAM bit one lights its dot; RAM bit zero leaves it unlit.
// (R8) Bit k of an entry controls the dot on common line k.
// (R9) Display-on command enables display, also in hold; display-off blanks it.
// (R10) All dots are driven lit while reset is asserted.
// (R11) Display goes off when reset ends; software must issue display-on.
// (R12) DC mode: entry 4g drives segment pins 4g..4g+3, bit 3 highest.
// (R13) DC mode: entries driving no pins remain ordinary read/write storage.
// (R14) Output type select is eight bits, write-only, loaded by immediate move.
// (R15) DC mode: type bit k set makes pins 4k..4k+3 open-drain, else push-pull.
// (R16) Static, half, third, quarter duty use one, two, three, four commons.
// (R17) Commons are selected in turn; drive polarity reverses every frame.
package lcdsd_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int SEG_NUM        = 32;
    localparam int COM_NUM        = 4;
    localparam int RAM_DEPTH      = 32;
    localparam int RAM_WIDTH      = 4;
    localparam int RAM_ADDR_W     = 5;
    localparam int TYPE_SEL_WIDTH = 8;
    localparam int DC_GROUP       = 4;
    localparam int LVL_W          = 2;
    localparam int SLOT_W         = 2;

    // ----------------------------------------------------------------
    // Drive modes (build-time)
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_STATIC = 3'h0;
    localparam logic [2:0] MODE_B2_D2  = 3'h1;
    localparam logic [2:0] MODE_B2_D3  = 3'h2;
    localparam logic [2:0] MODE_B3_D3  = 3'h3;
    localparam logic [2:0] MODE_B3_D4  = 3'h4;

    // ----------------------------------------------------------------
    // Alternating frequency divider
    // ----------------------------------------------------------------
    localparam logic [1:0] FREQ_DIV64  = 2'h0;
    localparam logic [1:0] FREQ_DIV512 = 2'h3;
    localparam int         DIV_BASE    = 64;
    localparam int         DIV_CNT_W   = 9;

    // ----------------------------------------------------------------
    // Drive level codes: VSS, VDD1, VDD2, VDD3
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_VSS  = 2'h0;
    localparam logic [1:0] LVL_VDD1 = 2'h1;
    localparam logic [1:0] LVL_VDD2 = 2'h2;
    localparam logic [1:0] LVL_VDD3 = 2'h3;

    // ----------------------------------------------------------------
    // Reset values and display states
    // ----------------------------------------------------------------
    localparam logic [7:0] TYPE_SEL_RST = 8'h00;

    typedef enum logic [2:0] {
        DSP_LIT = 3'b001,
        DSP_OFF = 3'b010,
        DSP_ON  = 3'b100
    } lcdsd_disp_t;

endpackage

// [lcdsd_alt_div.sv]
module lcdsd_alt_div #(
    parameter logic [1:0] DIV_SEL = lcdsd_pkg::FREQ_DIV512
) (
    input  wire logic sys_clk,   // System clock
    input  wire logic rst,       // Async reset, high
    input  wire logic src_tick,  // Display source clock tick
    output logic      alt_tick   // Alternating frequency tick
);

    localparam int                               DIVISOR  = lcdsd_pkg::DIV_BASE << DIV_SEL;
    localparam logic [lcdsd_pkg::DIV_CNT_W-1:0]  DIV_LAST = lcdsd_pkg::DIV_CNT_W'(DIVISOR - 1);

    typedef struct packed {
        logic [lcdsd_pkg::DIV_CNT_W-1:0] cnt;
        logic                            tick;
    } lcdsd_div_state_t;

    lcdsd_div_state_t s_r;
    lcdsd_div_state_t s_nxt;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    // (R3) Divide by selected ratio
    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (src_tick) begin
            if (s_r.cnt == DIV_LAST) begin
                s_nxt.cnt  = '0;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.cnt = lcdsd_pkg::DIV_CNT_W'(s_r.cnt + 1'b1);
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign alt_tick = s_r.tick;

    // Independent count of source ticks between output ticks
    logic [9:0] chk_ticks;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chk_ticks <= '0;
        end else if (alt_tick) begin
            chk_ticks <= src_tick ? 10'h001 : 10'h000;
        end else if (src_tick) begin
            chk_ticks <= 10'(chk_ticks + 1'b1);
        end
    end

    div_period_a: assert property (@(posedge sys_clk) disable iff (rst) // (R3)
        alt_tick |-> chk_ticks == 10'(DIVISOR))
        else $error("alternating tick period wrong");

endmodule

// [lcdsd_driver.sv]
module lcdsd_driver #(
    parameter logic [2:0] DRIVE_MODE = lcdsd_pkg::MODE_B3_D4,  // Mask option
    parameter logic [1:0] FREQ_SEL   = lcdsd_pkg::FREQ_DIV512, // Mask option
    parameter bit         DC_OUTPUT  = 1'b0                    // Mask option
) (
    input  wire logic                                             sys_clk,               // 50 MHz clock
    input  wire logic                                             rst,                   // Async reset, high
    input  wire logic                                             src_tick,              // Display source tick
    input  wire logic                                             ram_wr_en,             // RAM write strobe
    input  wire logic [lcdsd_pkg::RAM_ADDR_W-1:0]                 ram_wr_addr,           // RAM write entry
    input  wire logic [lcdsd_pkg::RAM_WIDTH-1:0]                  ram_wr_data,           // RAM write nibble
    input  wire logic                                             ram_rd_en,             // RAM read strobe
    input  wire logic [lcdsd_pkg::RAM_ADDR_W-1:0]                 ram_rd_addr,           // RAM read entry
    output logic      [lcdsd_pkg::RAM_WIDTH-1:0]                  ram_rd_data,           // RAM read nibble
    output logic                                                  ram_rd_valid,          // Read data valid
    input  wire logic                                             display_on_instruction,  // On command pulse
    input  wire logic                                             display_off_instruction, // Off command pulse
    input  wire logic                                             type_sel_wr,           // Type select load
    input  wire logic [lcdsd_pkg::TYPE_SEL_WIDTH-1:0]             type_sel_data,         // Immediate operand
    output logic      [lcdsd_pkg::SEG_NUM*lcdsd_pkg::LVL_W-1:0]   segment_output_line,   // Segment levels
    output logic      [lcdsd_pkg::COM_NUM*lcdsd_pkg::LVL_W-1:0]   common_output_line,    // Common levels
    output logic      [lcdsd_pkg::SEG_NUM-1:0]                    seg_dc_out,            // DC pin value
    output logic      [lcdsd_pkg::SEG_NUM-1:0]                    seg_dc_oe,             // DC pin drive enable
    output logic                                                  display_active         // Display shown
);

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // (R16) Commons in use per drive mode
    localparam logic [1:0] LAST_SLOT =
        (DRIVE_MODE == lcdsd_pkg::MODE_STATIC) ? 2'h0 :
        (DRIVE_MODE == lcdsd_pkg::MODE_B2_D2)  ? 2'h1 :
        (DRIVE_MODE == lcdsd_pkg::MODE_B3_D4)  ? 2'h3 : 2'h2;
    // (R2) Bias and top level from mask mode
    localparam bit         THIRD_BIAS = (DRIVE_MODE == lcdsd_pkg::MODE_B3_D3) ||
                                        (DRIVE_MODE == lcdsd_pkg::MODE_B3_D4);
    localparam logic [1:0] TOP_LVL    =
        (DRIVE_MODE == lcdsd_pkg::MODE_STATIC) ? lcdsd_pkg::LVL_VDD1 :
        THIRD_BIAS ? lcdsd_pkg::LVL_VDD3 : lcdsd_pkg::LVL_VDD2;

    localparam int SEG_BITS = lcdsd_pkg::SEG_NUM * lcdsd_pkg::LVL_W;
    localparam int COM_BITS = lcdsd_pkg::COM_NUM * lcdsd_pkg::LVL_W;

    typedef struct packed {
        logic [lcdsd_pkg::RAM_DEPTH-1:0][lcdsd_pkg::RAM_WIDTH-1:0] ram;
        logic [lcdsd_pkg::TYPE_SEL_WIDTH-1:0]                      type_sel;
        lcdsd_pkg::lcdsd_disp_t                                    disp;
        logic [lcdsd_pkg::SLOT_W-1:0]                              slot;
        logic                                                      pol;
        logic [lcdsd_pkg::RAM_WIDTH-1:0]                           rd_data;
        logic                                                      rd_valid;
        logic [SEG_BITS-1:0]                                       seg_lvl;
        logic [COM_BITS-1:0]                                       com_lvl;
        logic [lcdsd_pkg::SEG_NUM-1:0]                             dc_out;
        logic [lcdsd_pkg::SEG_NUM-1:0]                             dc_oe;
        logic                                                      active;
    } lcdsd_state_t;

    // ----------------------------------------------------------------
    // Level helpers
    // ----------------------------------------------------------------
    // (R17) Selected common swings full, other used commons sit at bias, unused ones at VSS
    function automatic logic [1:0] com_level(input int c, input logic [1:0] slot, input logic pol);
        logic [1:0] lvl;
        lvl = lcdsd_pkg::LVL_VSS;
        if (c > int'(LAST_SLOT)) begin
            lvl = lcdsd_pkg::LVL_VSS;
        end else if (2'(c) == slot) begin
            lvl = pol ? lcdsd_pkg::LVL_VSS : TOP_LVL;
        end else if (THIRD_BIAS) begin
            lvl = pol ? lcdsd_pkg::LVL_VDD2 : lcdsd_pkg::LVL_VDD1;
        end else begin
            lvl = lcdsd_pkg::LVL_VDD1;
        end
        return lvl;
    endfunction

    // (R7) Lit opposes selected common, unlit follows it
    function automatic logic [1:0] seg_level(input logic dot, input logic pol);
        logic [1:0] lvl;
        lvl = lcdsd_pkg::LVL_VSS;
        if (dot) begin
            lvl = pol ? TOP_LVL : lcdsd_pkg::LVL_VSS;
        end else if (THIRD_BIAS) begin
            lvl = pol ? lcdsd_pkg::LVL_VDD1 : lcdsd_pkg::LVL_VDD2;
        end else begin
            lvl = pol ? lcdsd_pkg::LVL_VSS : TOP_LVL;
        end
        return lvl;
    endfunction

    // Reset picture: level builds select every used common and light every dot; DC builds drive every DC pin low
    function automatic lcdsd_state_t rst_state();
        lcdsd_state_t r;
        r          = '0;
        r.type_sel = lcdsd_pkg::TYPE_SEL_RST;
        r.disp     = lcdsd_pkg::DSP_LIT;
        r.active   = 1'b1;
        if (DC_OUTPUT) begin
            r.dc_oe = '1;
        end else begin
            for (int c = 0; c < lcdsd_pkg::COM_NUM; c++) begin
                r.com_lvl[c*lcdsd_pkg::LVL_W +: lcdsd_pkg::LVL_W] = com_level(c, 2'(c), 1'b0);
            end
            for (int i = 0; i < lcdsd_pkg::SEG_NUM; i++) begin
                r.seg_lvl[i*lcdsd_pkg::LVL_W +: lcdsd_pkg::LVL_W] = seg_level(1'b1, 1'b0);
            end
        end
        return r;
    endfunction

    localparam lcdsd_state_t ST_RST = rst_state();

    lcdsd_state_t s_r;
    lcdsd_state_t s_nxt;
    logic         alt_tick;

    // ----------------------------------------------------------------
    // Alternating frequency
    // ----------------------------------------------------------------
    lcdsd_alt_div #(
        .DIV_SEL (FREQ_SEL)
    ) u_alt_div (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .src_tick (src_tick),
        .alt_tick (alt_tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Storage, commands, scan and pin drive in one pass
    always_comb begin
        logic       dot;
        logic [1:0] lvl;
        int         grp;
        dot = 1'b0;
        lvl = lcdsd_pkg::LVL_VSS;
        grp = 0;
        s_nxt          = s_r;
        s_nxt.rd_valid = 1'b0;

        // (R5) Nibble storage, one entry per segment
        if (ram_wr_en) begin
            s_nxt.ram[ram_wr_addr] = ram_wr_data;
        end
        // (R13) Reads see stored data; same-cycle write not forwarded
        if (ram_rd_en) begin
            s_nxt.rd_data  = s_r.ram[ram_rd_addr];
            s_nxt.rd_valid = 1'b1;
        end
        // (R14) Load only, no read path exists
        if (type_sel_wr) begin
            s_nxt.type_sel = type_sel_data;
        end

        // (R11) Lit picture ends one edge after reset release
        case (s_r.disp)
            lcdsd_pkg::DSP_LIT: s_nxt.disp = lcdsd_pkg::DSP_OFF;
            lcdsd_pkg::DSP_OFF: s_nxt.disp = lcdsd_pkg::DSP_OFF;
            lcdsd_pkg::DSP_ON:  s_nxt.disp = lcdsd_pkg::DSP_ON;
            default:            s_nxt.disp = lcdsd_pkg::DSP_OFF;
        endcase
        // (R9) Off wins if both commands arrive together
        if (display_off_instruction) begin
            s_nxt.disp = lcdsd_pkg::DSP_OFF;
        end else if (display_on_instruction) begin
            s_nxt.disp = lcdsd_pkg::DSP_ON;
        end

        // (R4) Frame lasts one tick per used common
        // (R17) Step common slot; flip polarity each frame
        if (alt_tick) begin
            if (s_r.slot == LAST_SLOT) begin
                s_nxt.slot = '0;
                s_nxt.pol  = ~s_r.pol;
            end else begin
                s_nxt.slot = 2'(s_r.slot + 1'b1);
            end
        end

        s_nxt.active = (s_r.disp != lcdsd_pkg::DSP_OFF);

        // (R6) Pins rebuilt every cycle from RAM, no software
        for (int c = 0; c < lcdsd_pkg::COM_NUM; c++) begin
            lvl = com_level(c, s_r.slot, s_r.pol);
            if (DC_OUTPUT || s_r.disp == lcdsd_pkg::DSP_OFF) begin
                lvl = lcdsd_pkg::LVL_VSS;
            end
            s_nxt.com_lvl[c*lcdsd_pkg::LVL_W +: lcdsd_pkg::LVL_W] = lvl;
        end
        for (int i = 0; i < lcdsd_pkg::SEG_NUM; i++) begin
            // (R8) Bit index equals active common
            dot = s_r.ram[i][s_r.slot];
            // (R10) Lit picture forces every dot on
            if (s_r.disp == lcdsd_pkg::DSP_LIT) begin
                dot = 1'b1;
            end
            lvl = seg_level(dot, s_r.pol);
            if (DC_OUTPUT || s_r.disp == lcdsd_pkg::DSP_OFF) begin
                lvl = lcdsd_pkg::LVL_VSS;
            end
            s_nxt.seg_lvl[i*lcdsd_pkg::LVL_W +: lcdsd_pkg::LVL_W] = lvl;

            // (R12) Group leader entry drives four pins
            grp = i / lcdsd_pkg::DC_GROUP;
            dot = s_r.ram[grp*lcdsd_pkg::DC_GROUP][i % lcdsd_pkg::DC_GROUP];
            if (DC_OUTPUT) begin
                s_nxt.dc_out[i] = dot;
                // (R15) Open drain drives low only
                s_nxt.dc_oe[i]  = s_r.type_sel[grp] ? ~dot : 1'b1;
            end else begin
                s_nxt.dc_out[i] = 1'b0;
                s_nxt.dc_oe[i]  = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset holds a fixed picture, all dots lit or in a DC build all DC pins low; scanning needs the clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // (R1) 32 segment and 4 common level outputs
    // Outputs straight from the state flops
    assign ram_rd_data         = s_r.rd_data;
    assign ram_rd_valid        = s_r.rd_valid;
    assign segment_output_line = s_r.seg_lvl;
    assign common_output_line  = s_r.com_lvl;
    assign seg_dc_out          = s_r.dc_out;
    assign seg_dc_oe           = s_r.dc_oe;
    assign display_active      = s_r.active;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence wr_then_rd_s;
        ram_wr_en ##1 (ram_rd_en && !ram_wr_en && ram_rd_addr == $past(ram_wr_addr));
    endsequence

    sequence reset_release_s;
        s_r.disp == lcdsd_pkg::DSP_LIT && !display_on_instruction;
    endsequence

    ram_readback_a: assert property (@(posedge sys_clk) disable iff (rst) // (R5)
        wr_then_rd_s |=> ram_rd_valid && ram_rd_data == $past(ram_wr_data, 2))
        else $error("display RAM readback mismatch");

    auto_off_a: assert property (@(posedge sys_clk) disable iff (rst) // (R11)
        reset_release_s |=> s_r.disp == lcdsd_pkg::DSP_OFF ##1 !display_active)
        else $error("display not off after reset");

    on_command_a: assert property (@(posedge sys_clk) disable iff (rst) // (R9)
        (display_on_instruction && !display_off_instruction) |=> s_r.disp == lcdsd_pkg::DSP_ON ##1 display_active)
        else $error("display-on command not taken");

    off_blank_a: assert property (@(posedge sys_clk) disable iff (rst) // (R9)
        display_off_instruction |=> ##1 (segment_output_line == '0 && common_output_line == '0))
        else $error("display not blanked by off command");

    lit_picture_a: assert property (@(posedge sys_clk) disable iff (rst) // (R10)
        (!DC_OUTPUT && s_r.disp == lcdsd_pkg::DSP_LIT) |=>
            segment_output_line[1:0] == seg_level(1'b1, $past(s_r.pol)))
        else $error("dot not lit after reset");

    seg_lit_a: assert property (@(posedge sys_clk) disable iff (rst) // (R7)
        (!DC_OUTPUT && s_r.disp == lcdsd_pkg::DSP_ON && s_r.ram[0][s_r.slot]) |=>
            segment_output_line[1:0] == ($past(s_r.pol) ? TOP_LVL : lcdsd_pkg::LVL_VSS))
        else $error("lit dot drive level wrong");

    com_select_a: assert property (@(posedge sys_clk) disable iff (rst) // (R8)
        (!DC_OUTPUT && s_r.disp == lcdsd_pkg::DSP_ON && s_r.slot == 2'h0) |=>
            common_output_line[1:0] == ($past(s_r.pol) ? lcdsd_pkg::LVL_VSS : TOP_LVL))
        else $error("selected common level wrong");

    frame_flip_a: assert property (@(posedge sys_clk) disable iff (rst) // (R17)
        (alt_tick && s_r.slot == LAST_SLOT) |=> (s_r.slot == 2'h0 && s_r.pol != $past(s_r.pol)))
        else $error("polarity did not reverse at frame end");

    slot_range_a: assert property (@(posedge sys_clk) disable iff (rst) // (R16)
        s_r.slot <= LAST_SLOT)
        else $error("common slot beyond commons in use");

    dc_map_a: assert property (@(posedge sys_clk) disable iff (rst) // (R12)
        DC_OUTPUT |=> seg_dc_out[31:28] == $past(s_r.ram[28]) && seg_dc_out[3:0] == $past(s_r.ram[0]))
        else $error("DC pin data mismatch");

    nmos_type_a: assert property (@(posedge sys_clk) disable iff (rst) // (R15)
        (DC_OUTPUT && s_r.type_sel[0]) |=> seg_dc_oe[3:0] == ~seg_dc_out[3:0])
        else $error("open-drain enable wrong");

    // Scan, drive and register-side invariants
    slot_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // (R17)
        !alt_tick |=> $stable(s_r.slot) && $stable(s_r.pol))
        else $error("scan moved without a tick");

    slot_step_a: assert property (@(posedge sys_clk) disable iff (rst) // (R4)
        (alt_tick && s_r.slot != LAST_SLOT) |=> s_r.slot == 2'($past(s_r.slot) + 1'b1) && $stable(s_r.pol))
        else $error("slot did not step");

    seg_unlit_a: assert property (@(posedge sys_clk) disable iff (rst) // (R7)
        (!DC_OUTPUT && s_r.disp == lcdsd_pkg::DSP_ON && !s_r.ram[0][s_r.slot]) |=>
            segment_output_line[1:0] != ($past(s_r.pol) ? TOP_LVL : lcdsd_pkg::LVL_VSS))
        else $error("unlit dot driven lit");

    dc_cmos_a: assert property (@(posedge sys_clk) disable iff (rst) // (R15)
        (DC_OUTPUT && !s_r.type_sel[0]) |=> seg_dc_oe[3:0] == 4'hF)
        else $error("push-pull pins not driven");

    dc_quiet_a: assert property (@(posedge sys_clk) disable iff (rst) // (R12)
        DC_OUTPUT |-> segment_output_line == '0 && common_output_line == '0)
        else $error("level drive active in DC mode");

    rd_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // (R5)
        ram_rd_valid |-> $past(ram_rd_en))
        else $error("read valid without request");

    off_wins_a: assert property (@(posedge sys_clk) disable iff (rst) // (R9)
        display_off_instruction |=> s_r.disp == lcdsd_pkg::DSP_OFF)
        else $error("off command not taken");

    type_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // (R14)
        !type_sel_wr |=> $stable(s_r.type_sel))
        else $error("type select changed without load");

    type_load_a: assert property (@(posedge sys_clk) disable iff (rst) // (R14)
        type_sel_wr |=> s_r.type_sel == $past(type_sel_data))
        else $error("type select not loaded");

    active_off_a: assert property (@(posedge sys_clk) disable iff (rst) // (R11)
        s_r.disp == lcdsd_pkg::DSP_OFF |=> !display_active)
        else $error("display shown while off");

endmodule

// [lcdsd_glass.sv]
// ----------------------------------------------------------------
// Panel model: a dot turns on only under the full bias swing
// ----------------------------------------------------------------
module lcdsd_glass (
    input  wire logic [63:0]  seg_lvl, // Segment level codes
    input  wire logic [7:0]   com_lvl, // Common level codes
    output logic      [127:0] dot_lit  // Dot s*4+c currently on
);
    timeunit 1ns;
    timeprecision 1ps;

    // dot per crossing
    // A third-bias swing leaves a dot dark, so only VSS against VDD3 counts
    always_comb begin
        for (int s = 0; s < 32; s++) begin
            for (int c = 0; c < 4; c++) begin
                dot_lit[s*4+c] = (seg_lvl[2*s+:2] == 2'h3 && com_lvl[2*c+:2] == 2'h0)
                              || (seg_lvl[2*s+:2] == 2'h0 && com_lvl[2*c+:2] == 2'h3);
            end
        end
    end
endmodule

// [lcdsd_driver_test.sv]
module lcdsd_driver_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic         sys_clk, rst, src_tick, wr_en, rd_en, on_cmd, off_cmd, type_wr;
    logic [4:0]   wr_addr, rd_addr;
    logic [3:0]   wr_data, rd_data, rd_data_dc;
    logic         rd_valid, rd_valid_dc, active;
    logic [7:0]   type_data, com_lvl, com_prev, type_m;
    logic [63:0]  seg_lvl;
    logic [31:0]  dc_out, dc_oe;
    logic [127:0] dot_lit, seen_or;
    logic [3:0]   ram_m [32];
    int           failures, total_checks, seed, n;

    // Scan instance runs at the fastest division to keep frames short
    lcdsd_driver #(.FREQ_SEL(lcdsd_pkg::FREQ_DIV64)) lcdsd_driver_i (.sys_clk(sys_clk), .rst(rst),
        .src_tick(src_tick), .ram_wr_en(wr_en), .ram_wr_addr(wr_addr), .ram_wr_data(wr_data),
        .ram_rd_en(rd_en), .ram_rd_addr(rd_addr), .ram_rd_data(rd_data), .ram_rd_valid(rd_valid),
        .display_on_instruction(on_cmd), .display_off_instruction(off_cmd), .type_sel_wr(type_wr),
        .type_sel_data(type_data), .segment_output_line(seg_lvl), .common_output_line(com_lvl),
        .seg_dc_out(), .seg_dc_oe(), .display_active(active));
    // Same stimulus into a DC-output build
    lcdsd_driver #(.DC_OUTPUT(1'b1)) lcdsd_driver_dc_i (.sys_clk(sys_clk), .rst(rst),
        .src_tick(src_tick), .ram_wr_en(wr_en), .ram_wr_addr(wr_addr), .ram_wr_data(wr_data),
        .ram_rd_en(rd_en), .ram_rd_addr(rd_addr), .ram_rd_data(rd_data_dc), .ram_rd_valid(rd_valid_dc),
        .display_on_instruction(on_cmd), .display_off_instruction(off_cmd), .type_sel_wr(type_wr),
        .type_sel_data(type_data), .segment_output_line(), .common_output_line(),
        .seg_dc_out(dc_out), .seg_dc_oe(dc_oe), .display_active());
    lcdsd_glass lcdsd_glass_i (.seg_lvl(seg_lvl), .com_lvl(com_lvl), .dot_lit(dot_lit));

    // ----------------------------------------------------------------
    // Clock, helpers and expectations
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Inputs move 1 ns after the edge so no race with sampling
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        rd_en = 1'b0;
        wr_addr = a;
        wr_data = d;
        wr_en = 1'b1;
        ram_m[a] = d;
        step(1);
    endtask

    task automatic rd(input logic [4:0] a);
        wr_en = 1'b0;
        rd_addr = a;
        rd_en = 1'b1;
        step(1);
        check({rd_valid, rd_data, rd_valid_dc, rd_data_dc}, {1'b1, ram_m[a], 1'b1, ram_m[a]});
    endtask

    // Two full frames so both drive polarities are covered
    task automatic scan();
        seen_or = '0;
        repeat (600) begin
            step(1);
            seen_or |= dot_lit;
        end
    endtask

    function automatic logic [127:0] exp_map();
        for (int s = 0; s < 32; s++) exp_map[s*4+:4] = ram_m[s];
    endfunction

    function automatic logic [63:0] exp_dc();
        for (int s = 0; s < 32; s++) begin
            exp_dc[s] = ram_m[s & 5'h1C][s % 4];
            exp_dc[32+s] = type_m[s/4] ? ~exp_dc[s] : 1'b1;
        end
    endfunction

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, src_tick} = 2'h3;
        {wr_en, rd_en, on_cmd, off_cmd, type_wr} = 5'h00;
        {wr_addr, rd_addr, wr_data, type_data, type_m} = '0;
        seed = 75932;
        for (int i = 0; i < 32; i++) ram_m[i] = 4'h0;
        step(3);
        check({active, dot_lit}, {1'b1, {128{1'b1}}});
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        step(2);
        check({active, seg_lvl, com_lvl, dc_oe, dc_out}, {1'b0, 72'h0, exp_dc()});
        $display("reset test done");
        for (int a = 0; a < 32; a++) wr(a[4:0], 4'($random(seed)));
        wr_en = 1'b0;
        type_data = 8'($random(seed));
        type_wr = 1'b1;
        step(1);
        type_wr = 1'b0;
        type_m = type_data;
        step(1);
        check({dc_oe, dc_out}, exp_dc());
        wr(5'h05, ~ram_m[5]);
        rd(5'h05);
        rd(5'h00);
        rd(5'h1F);
        rd(5'($random(seed)));
        $display("ram test done");
        {rd_en, on_cmd} = 2'h1;
        step(1);
        on_cmd = 1'b0;
        step(1);
        check(active, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wr(5'($random(seed)), 4'($random(seed)));
            wr_en = 1'b0;
            scan();
            check(seen_or, exp_map());
        end
        for (int k = 0; k < 2; k++) begin
            com_prev = com_lvl;
            n = 0;
            while (com_lvl === com_prev && n < 200) begin
                step(1);
                n++;
            end
        end
        check(n, 64);
        $display("scan test done");
        {on_cmd, off_cmd} = 2'h3;
        step(1);
        {on_cmd, off_cmd} = 2'h0;
        step(1);
        check({active, seg_lvl, com_lvl}, 73'h0);
        $display("off test done");
        summarize();
    end
endmodule
